// [design/nbl_cfg.svh]
// Offsets, field positions, reset values, NAND command bytes and timing counts for the block-lock host.
`ifndef NBL_CFG_SVH
`define NBL_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on APB)
`define NBL_OFF_CTRL       8'h00
`define NBL_OFF_CMD        8'h04
`define NBL_OFF_START_BLK  8'h08
`define NBL_OFF_END_BLK    8'h0c
`define NBL_OFF_STATUS     8'h10
`define NBL_OFF_LOCK_STATE 8'h14

// ==========================================================================
// Field positions and reset values
`define NBL_CTRL_LFE_BIT    0
`define NBL_CTRL_WPHOLD_BIT 1
`define NBL_CTRL_RST        2'h1
`define NBL_ST_PWRDONE_BIT  0
`define NBL_ST_BUSY_BIT     1
`define NBL_ST_ERR_BIT      2
`define NBL_ST_RB_BIT       3
`define NBL_ROW_PAD         5'h00

// ==========================================================================
// Pin cycle kinds
`define NBL_K_CMD  2'h0
`define NBL_K_ADDR 2'h1
`define NBL_K_READ 2'h2

// ==========================================================================
// NAND command bytes
`define NBL_NC_LOCK       8'h2a
`define NBL_NC_LOCK_TIGHT 8'h2c
`define NBL_NC_UNLOCK_LO  8'h23
`define NBL_NC_UNLOCK_HI  8'h24
`define NBL_NC_LOCK_STAT  8'h7a
`define NBL_NC_STATUS     8'h70

// ==========================================================================
// Timing: figures in ns, cycle counts rounded up, never below one
`define NBL_CLK_NS        50
`define NBL_T_PWR_NS      10000
`define NBL_T_STROBE_NS   60
`define NBL_T_HIGH_NS     20
`define NBL_T_WP_PULSE_NS 100
`define NBL_CEIL(t)       ((((t) + `NBL_CLK_NS - 1) / `NBL_CLK_NS) < 1 ? 1 : (((t) + `NBL_CLK_NS - 1) / `NBL_CLK_NS))
`define NBL_PWR_CYC       `NBL_CEIL(`NBL_T_PWR_NS)
`define NBL_STROBE_CYC    `NBL_CEIL(`NBL_T_STROBE_NS)
`define NBL_HIGH_CYC      `NBL_CEIL(`NBL_T_HIGH_NS)
`define NBL_WP_CYC        `NBL_CEIL(`NBL_T_WP_PULSE_NS)

`endif

// [design/nbl_pkg.sv]
// Types shared by the block-lock host modules.
package nbl_pkg;

	// ==========================================================================
	// Operations that software orders through the command register
	typedef enum logic [2:0] {
		NBL_OP_LOCK   = 3'h0,
		NBL_OP_UNLOCK = 3'h1,
		NBL_OP_TIGHT  = 3'h2,
		NBL_OP_LSR    = 3'h3,
		NBL_OP_POLL   = 3'h4,
		NBL_OP_WP     = 3'h5
	} nbl_op_t;

	// ==========================================================================
	// Sequencer states
	typedef enum logic [5:0] {
		NBL_ST_PWR    = 6'b000001,
		NBL_ST_IDLE   = 6'b000010,
		NBL_ST_RBWAIT = 6'b000100,
		NBL_ST_ISSUE  = 6'b001000,
		NBL_ST_CYCLE  = 6'b010000,
		NBL_ST_WPLOW  = 6'b100000
	} nbl_state_t;

	// ==========================================================================
	// Pin cycle states
	typedef enum logic [3:0] {
		NBL_PC_IDLE  = 4'b0001,
		NBL_PC_SETUP = 4'b0010,
		NBL_PC_LOW   = 4'b0100,
		NBL_PC_HIGH  = 4'b1000
	} nbl_pc_state_t;

endpackage : nbl_pkg

// [design/nbl_pin_cycle.sv]
// One NAND bus cycle: command latch, address latch or data read, with strobe timing.
`timescale 1ns/10ps
`include "nbl_cfg.svh"

module nbl_pin_cycle (
	input  wire logic       clk,       // System clock.
	input  wire logic       reset_n,   // Asynchronous reset, active low.
	input  wire logic       start,     // Begin one bus cycle.
	input  wire logic [1:0] kind,      // Cycle kind.
	input  wire logic [7:0] data,      // Byte to drive.
	input  wire logic [7:0] io_in,     // Data pins as seen.
	output logic            cle,       // Command latch enable.
	output logic            ale,       // Address latch enable.
	output logic            we_n,      // Write strobe.
	output logic            rd_n,      // Read strobe.
	output logic [7:0]      io_out,    // Data pins driven value.
	output logic            io_oe_n,   // Data pin enable, low drives.
	output logic [7:0]      rd_data,   // Byte sampled on a read.
	output logic            done       // Cycle finished, one pulse.
);

	localparam logic [3:0] LOW_CYC  = 4'(`NBL_STROBE_CYC);
	localparam logic [3:0] HIGH_CYC = 4'(`NBL_HIGH_CYC);

	nbl_pkg::nbl_pc_state_t st_q, st_d;
	logic [3:0]             cnt_q, cnt_d;
	logic [1:0]             kind_q, kind_d;
	logic                   cle_d, ale_d, we_n_d, rd_n_d, io_oe_n_d, done_d;
	logic [7:0]             io_out_d, rd_data_d;

	// ==========================================================================
	// Next state
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		kind_d    = kind_q;
		cle_d     = cle;
		ale_d     = ale;
		we_n_d    = we_n;
		rd_n_d    = rd_n;
		io_out_d  = io_out;
		io_oe_n_d = io_oe_n;
		rd_data_d = rd_data;
		done_d    = 1'b0;
		case (st_q)
			nbl_pkg::NBL_PC_IDLE: begin
				if (start) begin
					st_d      = nbl_pkg::NBL_PC_SETUP;
					kind_d    = kind;
					cle_d     = (kind == `NBL_K_CMD);
					ale_d     = (kind == `NBL_K_ADDR);
					io_out_d  = data;
					io_oe_n_d = (kind == `NBL_K_READ);
				end
			end
			nbl_pkg::NBL_PC_SETUP: begin
				st_d  = nbl_pkg::NBL_PC_LOW;
				cnt_d = LOW_CYC - 4'h1;
				if (kind_q == `NBL_K_READ) begin
					rd_n_d = 1'b0;
				end else begin
					we_n_d = 1'b0;
				end
			end
			nbl_pkg::NBL_PC_LOW: begin
				if (cnt_q == 4'h0) begin
					st_d   = nbl_pkg::NBL_PC_HIGH;
					cnt_d  = HIGH_CYC - 4'h1;
					we_n_d = 1'b1;
					rd_n_d = 1'b1;
					if (kind_q == `NBL_K_READ) begin
						rd_data_d = io_in;
					end
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			nbl_pkg::NBL_PC_HIGH: begin
				if (cnt_q == 4'h0) begin
					st_d      = nbl_pkg::NBL_PC_IDLE;
					cle_d     = 1'b0;
					ale_d     = 1'b0;
					io_oe_n_d = 1'b1;
					done_d    = 1'b1;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			default: begin
				st_d = nbl_pkg::NBL_PC_IDLE;
			end
		endcase
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q    <= nbl_pkg::NBL_PC_IDLE;
			cnt_q   <= 4'h0;
			kind_q  <= `NBL_K_CMD;
			cle     <= 1'b0;
			ale     <= 1'b0;
			we_n    <= 1'b1;
			rd_n    <= 1'b1;
			io_out  <= 8'h00;
			io_oe_n <= 1'b1;
			rd_data <= 8'h00;
			done    <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			kind_q  <= kind_d;
			cle     <= cle_d;
			ale     <= ale_d;
			we_n    <= we_n_d;
			rd_n    <= rd_n_d;
			io_out  <= io_out_d;
			io_oe_n <= io_oe_n_d;
			rd_data <= rd_data_d;
			done    <= done_d;
		end
	end

endmodule : nbl_pin_cycle

// [design/nbl_host.sv]
// Host controller that drives the block-lock protection of a NAND flash from APB registers.
//
// Operation
// - Unlock: 23h, start block, 24h, end block.
// - Start block not above end block.
// - Lock status read: 7Ah, block address, read.
// - No lock status read while device busy.
// - Enable high uses 7Ah, low uses 70h.
// - Wait 10us after power-up before commands.
// - Hold write-protect low during power transitions.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "nbl_cfg.svh"

module nbl_host #(
	parameter int BLK_W = 11                       // Block address width.
) (
	input  wire logic        clk,                     // System clock, 20 MHz.
	input  wire logic        reset_n,                 // Asynchronous reset, active low.
	input  wire logic        psel,                    // APB select.
	input  wire logic        penable,                 // APB enable.
	input  wire logic        pwrite,                  // APB direction.
	input  wire logic [7:0]  paddr,                   // APB byte address.
	input  wire logic [31:0] pwdata,                  // APB write data.
	output logic      [31:0] prdata,                  // APB read data.
	output logic             pready,                  // APB ready.
	output logic             pslverr,                 // APB error.
	output logic             nand_ce_n,               // Chip select.
	output logic             nand_cle,                // Command latch enable.
	output logic             nand_ale,                // Address latch enable.
	output logic             nand_we_n,               // Write strobe.
	output logic             read_strobe_n,           // Read strobe.
	output logic             nand_wp_n,               // Write protect.
	output logic             lock_feature_enable_pin, // Lock feature enable.
	input  wire logic [7:0]  nand_io_in,              // Data pins as seen.
	output logic      [7:0]  nand_io_out,             // Data pins driven value.
	output logic             nand_io_oe_n,            // Data pin enable, low drives.
	input  wire logic        nand_rb                  // Ready/busy, wired-OR, high ready.
);

	if (BLK_W < 1 || BLK_W > 11) begin : g_chk
		$error("BLK_W must lie between 1 and 11");
	end

	localparam logic [7:0] PWR_CYC = 8'(`NBL_PWR_CYC);
	localparam logic [3:0] WP_CYC  = 4'(`NBL_WP_CYC);

	// ==========================================================================
	// Declarations
	nbl_pkg::nbl_state_t st_q, st_d;
	nbl_pkg::nbl_op_t    op_q, op_d;
	logic [2:0]          idx_q, idx_d;
	logic [7:0]          pwr_cnt_q, pwr_cnt_d;
	logic [3:0]          wp_cnt_q, wp_cnt_d;
	logic [1:0]          ctrl_q, ctrl_d;
	logic [BLK_W-1:0]    sblk_q, sblk_d, eblk_q, eblk_d;
	logic [7:0]          lock_byte_q, lock_byte_d;
	logic                err_q, err_d, ce_n_d, wp_n_d;
	logic [31:0]         prdata_d;
	logic                pready_d, pslverr_d;
	logic                access, wr_fire, cmd_wr, mapped;
	logic [10:0]         step;
	logic [15:0]         srow, erow;
	logic                pc_done;
	logic [7:0]          pc_rd_data;

	// Row address bytes: block number sits above the five page bits.
	assign srow = 16'({11'(sblk_q), `NBL_ROW_PAD});
	assign erow = 16'({11'(eblk_q), `NBL_ROW_PAD});

	// ==========================================================================
	// Bus cycle sequence per operation: {last, kind, byte}
	function automatic logic [10:0] seq_step(input nbl_pkg::nbl_op_t op, input logic [2:0] idx,
	                                         input logic lfe, input logic [15:0] sr, input logic [15:0] er);
		logic [10:0] r;
		r = {1'b1, `NBL_K_READ, 8'h00};
		case (op)
			nbl_pkg::NBL_OP_LOCK:  r = {1'b1, `NBL_K_CMD, `NBL_NC_LOCK};
			nbl_pkg::NBL_OP_TIGHT: r = {1'b1, `NBL_K_CMD, `NBL_NC_LOCK_TIGHT};
			nbl_pkg::NBL_OP_UNLOCK: begin
				case (idx)
					3'h0:    r = {1'b0, `NBL_K_CMD, `NBL_NC_UNLOCK_LO};
					3'h1:    r = {1'b0, `NBL_K_ADDR, sr[7:0]};
					3'h2:    r = {1'b0, `NBL_K_ADDR, sr[15:8]};
					3'h3:    r = {1'b0, `NBL_K_CMD, `NBL_NC_UNLOCK_HI};
					3'h4:    r = {1'b0, `NBL_K_ADDR, er[7:0]};
					default: r = {1'b1, `NBL_K_ADDR, er[15:8]};
				endcase
			end
			nbl_pkg::NBL_OP_LSR: begin
				if (lfe) begin
					case (idx)
						3'h0:    r = {1'b0, `NBL_K_CMD, `NBL_NC_LOCK_STAT};
						3'h1:    r = {1'b0, `NBL_K_ADDR, sr[7:0]};
						3'h2:    r = {1'b0, `NBL_K_ADDR, sr[15:8]};
						default: r = {1'b1, `NBL_K_READ, 8'h00};
					endcase
				end else begin
					case (idx)
						3'h0:    r = {1'b0, `NBL_K_CMD, `NBL_NC_STATUS};
						default: r = {1'b1, `NBL_K_READ, 8'h00};
					endcase
				end
			end
			default: r = {1'b1, `NBL_K_READ, 8'h00};
		endcase
		return r;
	endfunction : seq_step

	assign step = seq_step(op_q, idx_q, ctrl_q[`NBL_CTRL_LFE_BIT], srow, erow);

	// ==========================================================================
	// APB slave
	assign access  = psel & penable;
	assign wr_fire = access & pready & pwrite & ~pslverr;
	assign cmd_wr  = wr_fire & (paddr == `NBL_OFF_CMD);
	assign mapped  = (paddr == `NBL_OFF_CTRL) | (paddr == `NBL_OFF_CMD) | (paddr == `NBL_OFF_START_BLK) |
	                 (paddr == `NBL_OFF_END_BLK) | (paddr == `NBL_OFF_STATUS) | (paddr == `NBL_OFF_LOCK_STATE);

	always_comb begin
		pready_d  = access & ~pready;
		pslverr_d = 1'b0;
		prdata_d  = prdata;
		ctrl_d    = ctrl_q;
		sblk_d    = sblk_q;
		eblk_d    = eblk_q;
		if (access & ~pready) begin
			pslverr_d = ~mapped | (pwrite & (paddr == `NBL_OFF_CMD) & (st_q != nbl_pkg::NBL_ST_IDLE));
			prdata_d  = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`NBL_OFF_CTRL:       prdata_d = 32'(ctrl_q);
					`NBL_OFF_CMD:        prdata_d = 32'(op_q);
					`NBL_OFF_START_BLK:  prdata_d = 32'(sblk_q);
					`NBL_OFF_END_BLK:    prdata_d = 32'(eblk_q);
					`NBL_OFF_STATUS:     prdata_d = 32'({nand_rb, err_q, st_q != nbl_pkg::NBL_ST_IDLE,
					                                     st_q != nbl_pkg::NBL_ST_PWR});
					`NBL_OFF_LOCK_STATE: prdata_d = 32'(lock_byte_q[2:0]);
					default:             prdata_d = 32'h0000_0000;
				endcase
			end
		end
		if (wr_fire) begin
			case (paddr)
				`NBL_OFF_CTRL:      ctrl_d = pwdata[1:0];
				`NBL_OFF_START_BLK: sblk_d = pwdata[BLK_W-1:0];
				`NBL_OFF_END_BLK:   eblk_d = pwdata[BLK_W-1:0];
				default:            ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			ctrl_q  <= `NBL_CTRL_RST;
			sblk_q  <= '0;
			eblk_q  <= '0;
		end else begin
			pready  <= pready_d;
			pslverr <= pslverr_d;
			prdata  <= prdata_d;
			ctrl_q  <= ctrl_d;
			sblk_q  <= sblk_d;
			eblk_q  <= eblk_d;
		end
	end

	// ==========================================================================
	// Operation sequencer
	always_comb begin
		st_d        = st_q;
		op_d        = op_q;
		idx_d       = idx_q;
		pwr_cnt_d   = pwr_cnt_q;
		wp_cnt_d    = wp_cnt_q;
		err_d       = err_q;
		lock_byte_d = lock_byte_q;
		ce_n_d      = nand_ce_n;
		case (st_q)
			nbl_pkg::NBL_ST_PWR: begin
				if (pwr_cnt_q == 8'h00) begin
					st_d = nbl_pkg::NBL_ST_IDLE;
				end else begin
					pwr_cnt_d = pwr_cnt_q - 8'h01;
				end
			end
			nbl_pkg::NBL_ST_IDLE: begin
				if (cmd_wr) begin
					op_d  = nbl_pkg::nbl_op_t'(pwdata[2:0]);
					idx_d = 3'h0;
					err_d = 1'b0;
					case (nbl_pkg::nbl_op_t'(pwdata[2:0]))
						nbl_pkg::NBL_OP_WP: begin
							st_d     = nbl_pkg::NBL_ST_WPLOW;
							wp_cnt_d = WP_CYC - 4'h1;
						end
						nbl_pkg::NBL_OP_UNLOCK: begin
							if (sblk_q > eblk_q) begin
								err_d = 1'b1;
							end else begin
								st_d = nbl_pkg::NBL_ST_ISSUE;
							end
						end
						nbl_pkg::NBL_OP_LSR, nbl_pkg::NBL_OP_POLL: st_d = nbl_pkg::NBL_ST_RBWAIT;
						nbl_pkg::NBL_OP_LOCK, nbl_pkg::NBL_OP_TIGHT: st_d = nbl_pkg::NBL_ST_ISSUE;
						default: err_d = 1'b1;
					endcase
				end
			end
			nbl_pkg::NBL_ST_RBWAIT: begin
				if (nand_rb) begin
					st_d = nbl_pkg::NBL_ST_ISSUE;
				end
			end
			nbl_pkg::NBL_ST_ISSUE: begin
				st_d   = nbl_pkg::NBL_ST_CYCLE;
				ce_n_d = 1'b0;
			end
			nbl_pkg::NBL_ST_CYCLE: begin
				if (pc_done) begin
					if (step[9:8] == `NBL_K_READ) begin
						lock_byte_d = pc_rd_data;
					end
					if (step[10]) begin
						st_d   = nbl_pkg::NBL_ST_IDLE;
						ce_n_d = 1'b1;
					end else begin
						idx_d = idx_q + 3'h1;
						st_d  = nbl_pkg::NBL_ST_ISSUE;
					end
				end
			end
			nbl_pkg::NBL_ST_WPLOW: begin
				if (wp_cnt_q == 4'h0) begin
					st_d = nbl_pkg::NBL_ST_IDLE;
				end else begin
					wp_cnt_d = wp_cnt_q - 4'h1;
				end
			end
			default: st_d = nbl_pkg::NBL_ST_IDLE;
		endcase
		// Write protect stays low through recovery, pulses and software hold.
		wp_n_d = ~((st_d == nbl_pkg::NBL_ST_PWR) | (st_d == nbl_pkg::NBL_ST_WPLOW) |
		           ctrl_d[`NBL_CTRL_WPHOLD_BIT]);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q                    <= nbl_pkg::NBL_ST_PWR;
			op_q                    <= nbl_pkg::NBL_OP_LOCK;
			idx_q                   <= 3'h0;
			pwr_cnt_q               <= PWR_CYC;
			wp_cnt_q                <= 4'h0;
			err_q                   <= 1'b0;
			lock_byte_q             <= 8'h00;
			nand_ce_n               <= 1'b1;
			nand_wp_n               <= 1'b0;
			lock_feature_enable_pin <= 1'b0;
		end else begin
			st_q                    <= st_d;
			op_q                    <= op_d;
			idx_q                   <= idx_d;
			pwr_cnt_q               <= pwr_cnt_d;
			wp_cnt_q                <= wp_cnt_d;
			err_q                   <= err_d;
			lock_byte_q             <= lock_byte_d;
			nand_ce_n               <= ce_n_d;
			nand_wp_n               <= wp_n_d;
			lock_feature_enable_pin <= ctrl_d[`NBL_CTRL_LFE_BIT];
		end
	end

	// ==========================================================================
	// Pin timing engine
	nbl_pin_cycle u_pin (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (st_q == nbl_pkg::NBL_ST_ISSUE),
		.kind    (step[9:8]),
		.data    (step[7:0]),
		.io_in   (nand_io_in),
		.cle     (nand_cle),
		.ale     (nand_ale),
		.we_n    (nand_we_n),
		.rd_n    (read_strobe_n),
		.io_out  (nand_io_out),
		.io_oe_n (nand_io_oe_n),
		.rd_data (pc_rd_data),
		.done    (pc_done)
	);

endmodule : nbl_host

// [verification/nbl_nand_model.sv]
// Behavioural NAND flash device that keeps per-block lock states.
`timescale 1ns/10ps

module nbl_nand_model #(
	parameter int protected_busy_time = 1000000 // Busy span in ns after an erase of a protected block.
) (
	input  wire logic       ce_n,   // Chip select.
	input  wire logic       cle,    // Command latch enable.
	input  wire logic       ale,    // Address latch enable.
	input  wire logic       we_n,   // Write strobe.
	input  wire logic       rd_n,   // Read strobe.
	input  wire logic       wp_n,   // Write protect.
	input  wire logic       lfe,    // Lock feature enable.
	input  wire logic [7:0] io_out, // Byte from the host.
	input  wire logic       oe_n,   // Host drives when low.
	input  wire logic       busy,   // Another device pulls ready/busy low.
	output logic      [7:0] io_in,  // Resolved data pins.
	output logic            rb      // Ready/busy after the pull-up.
);
	// ====================
	// Block states
	logic [15:0] unl = '0;
	logic [15:0] tgt = '0;
	logic [7:0]  cmd;
	logic [7:0]  a0;
	logic [7:0]  last = '0;
	logic        prot_busy = 1'b0;
	event        prot_op;
	logic [7:0]  st;
	logic [3:0]  sb;
	logic [3:0]  qb;
	int          na;

	assign rb = !busy && !prot_busy;
	always @(posedge we_n or negedge wp_n) if (!wp_n) begin
		unl = '0;
		tgt = '0;
	end else if (!ce_n) begin
		if (cle) begin
			cmd = io_out;
			na = 0;
			if (lfe && cmd == 8'h2a) unl = unl & tgt;
			if (lfe && cmd == 8'h2c) tgt = '1;
			if (lfe && cmd == 8'hd0 && !unl[sb]) -> prot_op;
		end else if (ale) begin
			if (na == 0) a0 = io_out;
			else if (cmd == 8'h23 || cmd == 8'h60) sb = {io_out[0], a0[7:5]};
			else if (cmd == 8'h7a) qb = {io_out[0], a0[7:5]};
			else if (cmd == 8'h24 && lfe)
				for (int b = 0; b < 16; b++)
					if (!tgt[b]) unl[b] = b >= sb && b <= {io_out[0], a0[7:5]};
			na++;
		end
	end
	// ====================
	// Data pins
	always_comb begin
		st = (cmd == 8'h7a) ? {5'h00, unl[qb], !tgt[qb], tgt[qb]} : {wp_n, 7'h40};
		io_in = !oe_n ? io_out : (!ce_n && !rd_n) ? st : ~last;
	end
	always @(io_in) if (!oe_n || !rd_n) last = io_in;
	// An erase aimed at a protected block only keeps the device busy.
	always @(prot_op) begin
		prot_busy = 1'b1;
		#(protected_busy_time);
		prot_busy = 1'b0;
	end
endmodule : nbl_nand_model

// [verification/nbl_host_monitor.sv]
// Assertion checker for the block-lock host pins and APB answer.
`timescale 1ns/10ps

module nbl_host_monitor (
	input wire logic       clk,                     // Clock.
	input wire logic       reset_n,                 // Reset, active low.
	input wire logic       psel,                    // APB select.
	input wire logic       penable,                 // APB enable.
	input wire logic       pready,                  // APB ready.
	input wire logic       nand_ce_n,               // Chip select.
	input wire logic       nand_cle,                // Command latch.
	input wire logic       nand_ale,                // Address latch.
	input wire logic       nand_we_n,               // Write strobe.
	input wire logic       read_strobe_n,           // Read strobe.
	input wire logic       nand_wp_n,               // Write protect.
	input wire logic       lock_feature_enable_pin, // Lock feature enable.
	input wire logic [7:0] nand_io_out,             // Driven byte.
	input wire logic       nand_io_oe_n,            // Drive enable, low drives.
	input wire logic       nand_rb                  // Ready/busy.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ====================
	// Helper state: cycles since reset, last command and address bytes after it
	logic [7:0] pwr_q, pwr_d, cmd_q, cmd_d;
	logic [1:0] na_q, na_d;
	logic       we_q;
	always_comb begin
		pwr_d = (pwr_q == 8'hff) ? pwr_q : pwr_q + 8'h01;
		cmd_d = cmd_q;
		na_d = na_q;
		if (we_q && !nand_we_n && nand_cle) begin
			cmd_d = nand_io_out;
			na_d = 2'h0;
		end else if (we_q && !nand_we_n && nand_ale && na_q != 2'h3) begin
			na_d = na_q + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwr_q <= 8'h00;
			cmd_q <= 8'h00;
			na_q <= 2'h0;
			we_q <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			cmd_q <= cmd_d;
			na_q <= na_d;
			we_q <= nand_we_n;
		end
	end
	// ====================
	// Properties
	sequence s_wait; !pready ##1 pready; endsequence
	sequence s_rd_low; !read_strobe_n ##1 read_strobe_n; endsequence
	property p_pready_wait; $rose(penable) && psel |-> s_wait; endproperty
	property p_pready_pulse; pready |=> !pready; endproperty
	property p_pwr_quiet; pwr_q < 8'hc8 |-> nand_ce_n && nand_we_n; endproperty
	property p_pwr_wp; pwr_q < 8'hc8 |-> !nand_wp_n; endproperty
	property p_cmd_lfe; $fell(nand_we_n) && nand_cle && (nand_io_out == 8'h7a || nand_io_out == 8'h70)
		|-> lock_feature_enable_pin == (nand_io_out == 8'h7a); endproperty
	property p_unlock_seq; $fell(nand_we_n) && nand_cle && nand_io_out == 8'h24
		|-> cmd_q == 8'h23 && na_q == 2'h2; endproperty
	property p_lsr_addr; $fell(read_strobe_n) && cmd_q == 8'h7a |-> na_q == 2'h2; endproperty
	property p_lsr_idle; $fell(nand_we_n) && nand_cle && nand_io_out == 8'h7a |-> nand_rb; endproperty
	property p_rd_strobe; $fell(read_strobe_n) |-> !nand_ce_n && nand_io_oe_n ##1 s_rd_low; endproperty
	property p_latch_frame; !nand_we_n |-> !nand_ce_n && (nand_cle ^ nand_ale) && !nand_io_oe_n; endproperty
	property p_wp_pulse; $fell(nand_wp_n) |=> !nand_wp_n ##1 nand_wp_n; endproperty
	a_pready_wait: assert property (p_pready_wait) else $error("pready not in second access cycle");
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
	a_pwr_quiet: assert property (p_pwr_quiet) else $error("bus cycle during recovery");
	a_pwr_wp: assert property (p_pwr_wp) else $error("write protect released early");
	a_cmd_lfe: assert property (p_cmd_lfe) else $error("status command against enable pin");
	a_unlock_seq: assert property (p_unlock_seq) else $error("bad unlock sequence");
	a_lsr_addr: assert property (p_lsr_addr) else $error("status read without block address");
	a_lsr_idle: assert property (p_lsr_idle) else $error("status read while busy");
	a_rd_strobe: assert property (p_rd_strobe) else $error("bad read strobe");
	a_latch_frame: assert property (p_latch_frame) else $error("bad write strobe framing");
	a_wp_pulse: assert property (p_wp_pulse) else $error("bad write protect pulse");
endmodule : nbl_host_monitor

bind nbl_host nbl_host_monitor nbl_host_monitor_i (.clk(clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pready(pready), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale),
	.nand_we_n(nand_we_n), .read_strobe_n(read_strobe_n), .nand_wp_n(nand_wp_n),
	.lock_feature_enable_pin(lock_feature_enable_pin), .nand_io_out(nand_io_out),
	.nand_io_oe_n(nand_io_oe_n), .nand_rb(nand_rb));

// [verification/nbl_host_tb_top.sv]
// Self-checking bench for the block-lock host against the NAND model.
`timescale 1ns/10ps
`include "nbl_cfg.svh"

module nbl_host_tb_top;
	logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, busy = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, er, ce_n, cle, ale, we_n, rd_n, wp_n, lfe, oe_n, rb;
	logic [7:0]  io_in, io_out;
	logic [15:0] unl = '0, tgt = '0;
	int          err_total = 0, compares = 0, seed = 43, s, e;

	always #25 clk = ~clk;

	nbl_host #(.BLK_W(4)) nbl_host_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(rd_n),
		.nand_wp_n(wp_n), .lock_feature_enable_pin(lfe), .nand_io_in(io_in), .nand_io_out(io_out),
		.nand_io_oe_n(oe_n), .nand_rb(rb));
	nbl_nand_model nbl_nand_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .rd_n(rd_n),
		.wp_n(wp_n), .lfe(lfe), .io_out(io_out), .oe_n(oe_n), .busy(busy), .io_in(io_in), .rb(rb));

	// ====================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic op(input int o);
		apb(1'b1, `NBL_OFF_CMD, o);
		do apb(1'b0, `NBL_OFF_STATUS, '0); while (rd[`NBL_ST_BUSY_BIT] !== 1'b0);
	endtask : op
	function automatic void upd(input int o, input int a, input int b);
		for (int k = 0; k < 16; k++) begin
			if (o == 0 && !tgt[k]) unl[k] = 1'b0;
			if (o == 2) tgt[k] = 1'b1;
			if (o == 5) {unl[k], tgt[k]} = 2'b00;
			if (o == 1 && a <= b && !tgt[k]) unl[k] = k >= a && k <= b;
		end
	endfunction : upd
	task automatic cmd(input int o, input int a, input int b);
		apb(1'b1, `NBL_OFF_START_BLK, a);
		apb(1'b1, `NBL_OFF_END_BLK, b);
		op(o);
		upd(o, a, b);
	endtask : cmd
	task automatic lsr(input int b);
		apb(1'b1, `NBL_OFF_START_BLK, b);
		op(3);
		apb(1'b0, `NBL_OFF_LOCK_STATE, '0);
		chk(rd, {29'h0, unl[b], !tgt[b], tgt[b]});
		op(4);
		apb(1'b0, `NBL_OFF_LOCK_STATE, '0);
		chk(rd, {29'h0, unl[b], !tgt[b], tgt[b]});
	endtask : lsr
	task automatic results();
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// ====================
	// Scenarios
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, `NBL_OFF_CTRL, '0);
		chk(rd, 32'h1);
		apb(1'b1, `NBL_OFF_CMD, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 8'h18, '0);
		chk({31'h0, er}, 32'h1);
		do apb(1'b0, `NBL_OFF_STATUS, '0); while (rd[`NBL_ST_PWRDONE_BIT] !== 1'b1);
		lsr(5);
		for (int i = 0; i < 8; i++) begin
			s = {$random(seed)} % 16;
			e = (i == 0) ? s : s + {$random(seed)} % (16 - s);
			cmd(1, s, e);
			if (i == 2) cmd(0, 0, 0);
			if (i == 3) cmd(2, 0, 0);
			if (i == 5) cmd(5, 0, 0);
			lsr(s);
			lsr(e);
			lsr((s + 15) % 16);
			lsr((e + 1) % 16);
		end
		cmd(1, 9, 2);
		chk({31'h0, rd[`NBL_ST_ERR_BIT]}, 32'h1);
		lsr(9);
		busy <= 1'b1;
		apb(1'b1, `NBL_OFF_CMD, 32'h3);
		repeat (20) @(posedge clk);
		chk({31'h0, ce_n}, 32'h1);
		apb(1'b0, `NBL_OFF_STATUS, '0);
		chk({28'h0, rd[3:0]}, 32'h3);
		apb(1'b1, `NBL_OFF_CMD, 32'h4);
		chk({31'h0, er}, 32'h1);
		busy <= 1'b0;
		do apb(1'b0, `NBL_OFF_STATUS, '0); while (rd[`NBL_ST_BUSY_BIT] !== 1'b0);
		apb(1'b0, `NBL_OFF_LOCK_STATE, '0);
		chk(rd, {29'h0, unl[9], !tgt[9], tgt[9]});
		apb(1'b0, `NBL_OFF_CTRL, '0);
		chk(rd, 32'h1);
		lsr(3);
		apb(1'b1, `NBL_OFF_CTRL, 32'h0);
		op(3);
		apb(1'b0, `NBL_OFF_LOCK_STATE, '0);
		chk(rd, 32'h0);
		results();
	end
	initial begin
		#(50 * 60000);
		err_total++;
		results();
	end
endmodule : nbl_host_tb_top
